/* File: src/core_alu.sv */
// Eight-bit arithmetic and logic unit, purely combinational
`timescale 1ns/1ns
module core_alu (
	alu_link.unit lnk
);
	import core_regs_pkg::*;

	logic cin;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [15:0] prod;
	logic [8:0] dec_adj;

	// Single-bit mask from a three-bit index
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction

	// Result, flags and write strobes per operation; flags default to held values
	always_comb begin
		cin = (lnk.op == OP_ADDC) && lnk.cy_in;
		sum = 9'h000;
		nib = 5'h00;
		prod = 16'h0000;
		dec_adj = {1'b0, lnk.a};
		lnk.res = lnk.a;
		lnk.hi = lnk.aux;
		lnk.cy = lnk.cy_in;
		lnk.ac = lnk.ac_in;
		lnk.ov = lnk.ov_in;
		lnk.wr_acc = 1'b1;
		lnk.wr_aux = 1'b0;
		lnk.bit_val = 1'b0;
		case (lnk.op)
			OP_ADD, OP_ADDC: begin
				sum = {1'b0, lnk.a} + {1'b0, lnk.b} + {8'h00, cin};
				nib = {1'b0, lnk.a[3:0]} + {1'b0, lnk.b[3:0]} + {4'h0, cin};
				lnk.res = sum[7:0];
				lnk.cy = sum[8];
				lnk.ac = nib[4];
				lnk.ov = (lnk.a[7] == lnk.b[7]) && (sum[7] != lnk.a[7]);
			end
			OP_SUBB: begin
				sum = {1'b0, lnk.a} - {1'b0, lnk.b} - {8'h00, lnk.cy_in};
				nib = {1'b0, lnk.a[3:0]} - {1'b0, lnk.b[3:0]} - {4'h0, lnk.cy_in};
				lnk.res = sum[7:0];
				lnk.cy = sum[8];
				lnk.ac = nib[4];
				lnk.ov = (lnk.a[7] != lnk.b[7]) && (sum[7] != lnk.a[7]);
			end
			OP_INC: lnk.res = lnk.a + 8'h01;
			OP_DEC: lnk.res = lnk.a - 8'h01;
			OP_MUL: begin
				prod = {8'h00, lnk.a} * {8'h00, lnk.aux};
				lnk.res = prod[7:0];
				lnk.hi = prod[15:8];
				lnk.wr_aux = 1'b1;
				lnk.cy = 1'b0;
				lnk.ov = |prod[15:8];
			end
			OP_DIV: begin
				// Divide by zero flags overflow and leaves both bytes unchanged
				lnk.cy = 1'b0;
				lnk.ov = (lnk.aux == 8'h00);
				if (lnk.aux != 8'h00) begin
					lnk.res = lnk.a / lnk.aux;
					lnk.hi = lnk.a % lnk.aux;
					lnk.wr_aux = 1'b1;
				end
			end
			OP_DA: begin
				if (lnk.a[3:0] > 4'h9 || lnk.ac_in) begin
					dec_adj = dec_adj + 9'h006;
				end
				if (dec_adj[7:4] > 4'h9 || lnk.cy_in || dec_adj[8]) begin
					dec_adj = dec_adj + 9'h060;
				end
				lnk.res = dec_adj[7:0];
				lnk.cy = lnk.cy_in | dec_adj[8];
			end
			OP_CMP: begin
				lnk.wr_acc = 1'b0;
				lnk.cy = (lnk.a < lnk.b);
			end
			OP_AND: lnk.res = lnk.a & lnk.b;
			OP_OR: lnk.res = lnk.a | lnk.b;
			OP_XOR: lnk.res = lnk.a ^ lnk.b;
			OP_CPL: lnk.res = ~lnk.a;
			OP_RL: lnk.res = {lnk.a[6:0], lnk.a[7]};
			OP_RR: lnk.res = {lnk.a[0], lnk.a[7:1]};
			OP_RLC: begin
				lnk.res = {lnk.a[6:0], lnk.cy_in};
				lnk.cy = lnk.a[7];
			end
			OP_RRC: begin
				lnk.res = {lnk.cy_in, lnk.a[7:1]};
				lnk.cy = lnk.a[0];
			end
			OP_SETC, OP_CLRC, OP_CPLC: begin
				lnk.wr_acc = 1'b0;
				lnk.cy = (lnk.op == OP_SETC) | ((lnk.op == OP_CPLC) & ~lnk.cy_in);
			end
			OP_SETB: lnk.res = lnk.a | bit_mask(lnk.b[2:0]);
			OP_CLRB: lnk.res = lnk.a & ~bit_mask(lnk.b[2:0]);
			OP_CPLB: lnk.res = lnk.a ^ bit_mask(lnk.b[2:0]);
			OP_TESTB: begin
				lnk.wr_acc = 1'b0;
				lnk.bit_val = |(lnk.a & bit_mask(lnk.b[2:0]));
			end
			default: lnk.wr_acc = 1'b0;
		endcase
	end
endmodule // core_alu

/* File: src/core_links_if.sv */
// Interfaces joining the register file to its arithmetic and pointer units
`timescale 1ns/1ns
interface alu_link;
	import core_regs_pkg::*;
	alu_op_t op;
	logic [7:0] a, b, aux, res, hi;
	logic cy_in, ac_in, ov_in, cy, ac, ov, wr_acc, wr_aux, bit_val;
	modport core(output op, a, b, aux, cy_in, ac_in, ov_in,
		input res, hi, cy, ac, ov, wr_acc, wr_aux, bit_val);
	modport unit(input op, a, b, aux, cy_in, ac_in, ov_in,
		output res, hi, cy, ac, ov, wr_acc, wr_aux, bit_val);
endinterface // alu_link

interface ptr_link;
	logic wr, move_done;
	logic [7:0] addr, wdata, ctrl;
	logic [15:0] dp0, dp1, data_address;
	modport core(output wr, move_done, addr, wdata, input ctrl, dp0, dp1, data_address);
	modport unit(input wr, move_done, addr, wdata, output ctrl, dp0, dp1, data_address);
endinterface // ptr_link

/* File: src/core_regs_pkg.sv */
// Package: addresses, reset values, field positions and op codes of the core register set
package core_regs_pkg;
	// ----------------------------------------------------------------
	// Register addresses in the special-function space
	// ----------------------------------------------------------------
	localparam logic [7:0] STACK_LOW_ADDR = 8'h81;
	localparam logic [7:0] PTR0_LOW_ADDR = 8'h82;
	localparam logic [7:0] PTR0_HIGH_ADDR = 8'h83;
	localparam logic [7:0] PTR1_LOW_ADDR = 8'h84;
	localparam logic [7:0] PTR1_HIGH_ADDR = 8'h85;
	localparam logic [7:0] PTR_CTRL_ADDR = 8'h86;
	localparam logic [7:0] STACK_HIGH_ADDR = 8'h9b;
	localparam logic [7:0] ACC_ADDR = 8'he0;
	localparam logic [7:0] AUX_ADDR = 8'hf0;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [8:0] STACK_RST = 9'h007;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] PTR_CTRL_RST = 8'h80;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	// ----------------------------------------------------------------
	// Pointer control fields and vector layout
	// ----------------------------------------------------------------
	localparam int SEL_BIT = 0;
	localparam int TOGGLE_BIT = 2;
	localparam int STEP_EN_BIT = 3;
	localparam int DIR1_BIT = 4;
	localparam int DIR0_BIT = 5;
	localparam int SPACING_BIT = 6;
	localparam int BASE_BIT = 7;
	localparam logic [7:0] PTR_CTRL_WMASK = 8'hfd;
	localparam logic [15:0] VEC_BASE_LOW = 16'h0300;
	localparam logic [15:0] VEC_BASE_HIGH = 16'h8000;
	localparam logic [15:0] VEC_STRIDE = 16'h0008;
	localparam logic [15:0] VEC_SHIFT = 16'h0003;
	localparam int VEC_NUM_W = 4;
	// ----------------------------------------------------------------
	// Operation codes
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_ADD, OP_ADDC, OP_SUBB, OP_INC, OP_DEC, OP_MUL, OP_DIV, OP_DA,
		OP_CMP, OP_AND, OP_OR, OP_XOR, OP_CPL, OP_RL, OP_RR, OP_RLC, OP_RRC,
		OP_SETC, OP_CLRC, OP_CPLC, OP_SETB, OP_CLRB, OP_CPLB, OP_TESTB
	} alu_op_t;
	typedef enum logic [2:0] {
		STK_NONE, STK_PUSH, STK_POP, STK_LCALL, STK_ACALL, STK_RET, STK_RETI, STK_IRQ
	} stack_op_t;
endpackage

/* File: src/cpu_core_pointer_registers.sv */
// Core register file: accumulator, auxiliary, stack pointer, data pointers, vectors
`timescale 1ns/1ns
// Contract
// - Accumulator eight bits, takes results, resets zero
// - Multiply high byte, divide remainder into auxiliary
// - Auxiliary otherwise plain read/write, resets zero
// - Low stack pointer writable, resets to 07
// - Stack instructions and interrupt entry move pointer
// - Stack high holds one bit, others zero
// - Stack high bit follows the same operations
// - Two pointers, each two addressable bytes
// - Data moves use the selected pointer
// - Four pointer bytes read/write, reset zero
// - Spacing bit picks vector offset formula
// - Base bit picks table start; field resets 1
// - Bit five sets first pointer step direction
// - Arithmetic updates status flags per result
// - Unit supports full arithmetic and bit set
// - Classic instruction set, same codes
// - Select bit zero picks first pointer
// - Bit four sets second pointer step direction
// - Bit three enables automatic pointer stepping
// - Bit two enables automatic select toggling
module cpu_core_pointer_registers (
	input logic clk_sys,
	input logic rstn,
	input logic [7:0] sfr_addr,
	input logic [7:0] sfr_wdata,
	input logic sfr_wr,
	input logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input logic alu_go,
	input core_regs_pkg::alu_op_t alu_op,
	input logic [7:0] alu_operand,
	input core_regs_pkg::stack_op_t stack_op,
	input logic move_done,
	input logic [core_regs_pkg::VEC_NUM_W-1:0] irq_num,
	output logic [7:0] accumulator,
	output logic [7:0] aux_out,
	output logic [3:0] psw_flags,
	output logic bit_test,
	output logic [8:0] stack_address,
	output logic [15:0] data_address,
	output logic [15:0] vector_address
);
	import core_regs_pkg::*;

	// ----------------------------------------------------------------
	// Units
	// ----------------------------------------------------------------
	alu_link alu_bus();
	ptr_link ptr_bus();

	core_alu u_alu (
		.lnk(alu_bus)
	);

	data_pointer_unit u_ptr (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.lnk(ptr_bus)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	logic wr_sp, wr_sph, wr_acc, wr_aux;
	logic alu_acc, alu_aux;
	logic [7:0] next_acc, next_aux;
	logic [8:0] stack_step, stack_sum, next_stack;
	logic [3:0] next_flags;
	logic [7:0] next_rdata;
	logic next_hit;
	logic [15:0] vec_num, vec_offset, vec_base, next_vector;

	// Register-bus write strobes
	assign wr_sp = sfr_wr && (sfr_addr == STACK_LOW_ADDR);
	assign wr_sph = sfr_wr && (sfr_addr == STACK_HIGH_ADDR);
	assign wr_acc = sfr_wr && (sfr_addr == ACC_ADDR);
	assign wr_aux = sfr_wr && (sfr_addr == AUX_ADDR);

	// Pointer unit sees the same bus and the move-complete strobe
	assign ptr_bus.wr = sfr_wr;
	assign ptr_bus.addr = sfr_addr;
	assign ptr_bus.wdata = sfr_wdata;
	assign ptr_bus.move_done = move_done;
	assign data_address = ptr_bus.data_address;

	// ----------------------------------------------------------------
	// Accumulator, auxiliary and flags
	// ----------------------------------------------------------------
	assign alu_bus.op = alu_op;
	assign alu_bus.a = accumulator;
	assign alu_bus.b = alu_operand;
	assign alu_bus.aux = aux_out;
	assign alu_bus.cy_in = psw_flags[3];
	assign alu_bus.ac_in = psw_flags[2];
	assign alu_bus.ov_in = psw_flags[1];
	assign alu_acc = alu_go && alu_bus.wr_acc;
	assign alu_aux = alu_go && alu_bus.wr_aux;

	// Explicit register writes take priority over a result in the same cycle
	assign next_acc = wr_acc ? sfr_wdata : (alu_acc ? alu_bus.res : accumulator);
	assign next_aux = wr_aux ? sfr_wdata : (alu_aux ? alu_bus.hi : aux_out);
	// Parity always tracks the accumulator, so it is taken from the next value
	assign next_flags = alu_go ? {alu_bus.cy, alu_bus.ac, alu_bus.ov, ^next_acc} :
		{psw_flags[3:1], ^next_acc};

	// Data registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			accumulator <= BYTE_RST;
			aux_out <= BYTE_RST;
			psw_flags <= FLAGS_RST;
		end else begin
			accumulator <= next_acc;
			aux_out <= next_aux;
			psw_flags <= next_flags;
		end
	end

	// Bit test result held for the branch decision
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			bit_test <= 1'b0;
		end else if (alu_go && alu_op == OP_TESTB) begin
			bit_test <= alu_bus.bit_val;
		end
	end

	// ----------------------------------------------------------------
	// Stack pointer
	// ----------------------------------------------------------------
	// Calls and interrupt entry save two bytes, returns restore two
	always_comb begin
		case (stack_op)
			STK_PUSH: stack_step = 9'h001;
			STK_POP: stack_step = 9'h1ff;
			STK_LCALL, STK_ACALL, STK_IRQ: stack_step = 9'h002;
			STK_RET, STK_RETI: stack_step = 9'h1fe;
			default: stack_step = 9'h000;
		endcase
	end

	// The nine-bit address carries into the high bit; writes override each part
	assign stack_sum = stack_address + stack_step;
	assign next_stack[7:0] = wr_sp ? sfr_wdata : stack_sum[7:0];
	assign next_stack[8] = wr_sph ? sfr_wdata[0] : stack_sum[8];

	// Stack register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stack_address <= STACK_RST;
		end else begin
			stack_address <= next_stack;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt vector address
	// ----------------------------------------------------------------
	assign vec_num = {{(16 - VEC_NUM_W){1'b0}}, irq_num};
	// Compact spacing packs vectors three bytes apart for small code spaces
	assign vec_offset = ptr_bus.ctrl[SPACING_BIT] ? 16'((vec_num + 16'h0001) * VEC_SHIFT) :
		16'(vec_num * VEC_STRIDE + VEC_SHIFT);
	assign vec_base = ptr_bus.ctrl[BASE_BIT] ? VEC_BASE_HIGH : VEC_BASE_LOW;
	assign next_vector = vec_base + vec_offset;

	// Vector for the pending source, one cycle behind the number
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			vector_address <= PTR_RST;
		end else begin
			vector_address <= next_vector;
		end
	end

	// ----------------------------------------------------------------
	// Register read path
	// ----------------------------------------------------------------
	// Unmapped addresses read zero and leave the hit flag low
	assign next_rdata = (sfr_addr == STACK_LOW_ADDR) ? stack_address[7:0] :
		(sfr_addr == STACK_HIGH_ADDR) ? {7'h00, stack_address[8]} :
		(sfr_addr == PTR0_LOW_ADDR) ? ptr_bus.dp0[7:0] :
		(sfr_addr == PTR0_HIGH_ADDR) ? ptr_bus.dp0[15:8] :
		(sfr_addr == PTR1_LOW_ADDR) ? ptr_bus.dp1[7:0] :
		(sfr_addr == PTR1_HIGH_ADDR) ? ptr_bus.dp1[15:8] :
		(sfr_addr == PTR_CTRL_ADDR) ? ptr_bus.ctrl :
		(sfr_addr == ACC_ADDR) ? accumulator :
		(sfr_addr == AUX_ADDR) ? aux_out : BYTE_RST;
	assign next_hit = (sfr_addr == STACK_LOW_ADDR) || (sfr_addr == STACK_HIGH_ADDR) ||
		(sfr_addr >= PTR0_LOW_ADDR && sfr_addr <= PTR_CTRL_ADDR) ||
		(sfr_addr == ACC_ADDR) || (sfr_addr == AUX_ADDR);

	// Read data registered one cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sfr_rdata <= BYTE_RST;
			sfr_hit <= 1'b0;
		end else begin
			sfr_rdata <= sfr_rd ? next_rdata : BYTE_RST;
			sfr_hit <= sfr_rd && next_hit;
		end
	end

	// ----------------------------------------------------------------
	// Assertions and cover points
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	chk_acc_add_result: assert property (
		alu_go && alu_op == OP_ADD && !wr_acc |=>
		accumulator == 8'($past(accumulator) + $past(alu_operand)))
		else $error("accumulator missed the add result");

	chk_mul_high_byte: assert property (
		alu_go && alu_op == OP_MUL && !wr_aux |=>
		aux_out == 8'(({8'h00, $past(accumulator)} * {8'h00, $past(aux_out)}) >> 8))
		else $error("auxiliary missed the product high byte");

	chk_aux_plain_hold: assert property (
		!alu_go && !wr_aux |=> $stable(aux_out))
		else $error("auxiliary changed without a cause");

	chk_sp_write_read: assert property (
		wr_sp ##1 sfr_rd && sfr_addr == STACK_LOW_ADDR && !sfr_wr && stack_op == STK_NONE
		|=> sfr_rdata == $past(sfr_wdata, 2))
		else $error("stack low write not read back");

	chk_push_step_one: assert property (
		stack_op == STK_PUSH && !wr_sp && !wr_sph |=>
		stack_address == 9'($past(stack_address) + 9'h001))
		else $error("push did not advance the stack by one");

	chk_call_step_two: assert property (
		(stack_op == STK_LCALL || stack_op == STK_IRQ) && !wr_sp && !wr_sph |=>
		stack_address == 9'($past(stack_address) + 9'h002))
		else $error("call did not advance the stack by two");

	chk_sph_read_mask: assert property (
		sfr_rd && sfr_addr == STACK_HIGH_ADDR |=> sfr_rdata[7:1] == 7'h00 && sfr_hit)
		else $error("stack high read unused bits");

	chk_vector_formula: assert property (
		!ptr_bus.ctrl[SPACING_BIT] && !ptr_bus.ctrl[BASE_BIT] && !sfr_wr |=>
		vector_address == 16'(VEC_BASE_LOW + {12'h000, $past(irq_num)} * 16'h0008 + 16'h0003))
		else $error("vector address wrong for wide spacing");

	chk_vector_base_high: assert property (
		ptr_bus.ctrl[BASE_BIT] && ptr_bus.ctrl[SPACING_BIT] && !sfr_wr |=>
		vector_address == 16'(VEC_BASE_HIGH + ({12'h000, $past(irq_num)} + 16'h0001) * 16'h0003))
		else $error("vector address wrong for compact spacing");

	chk_parity_tracks: assert property (
		psw_flags[0] == ^accumulator)
		else $error("parity flag does not match accumulator");

	chk_step_down_zero: assert property (
		move_done && !sfr_wr && ptr_bus.ctrl[STEP_EN_BIT] && !ptr_bus.ctrl[SEL_BIT] &&
		ptr_bus.ctrl[DIR0_BIT] |=> ptr_bus.dp0 == 16'($past(ptr_bus.dp0) - 16'h0001))
		else $error("first pointer did not step down");

	chk_toggle_select: assert property (
		move_done && !sfr_wr && ptr_bus.ctrl[TOGGLE_BIT] |=>
		ptr_bus.ctrl[SEL_BIT] != $past(ptr_bus.ctrl[SEL_BIT]))
		else $error("select did not toggle after move");

	chk_no_step_idle: assert property (
		!move_done && !sfr_wr |=> $stable(ptr_bus.dp0) && $stable(ptr_bus.dp1) &&
		data_address == (ptr_bus.ctrl[SEL_BIT] ? ptr_bus.dp1 : ptr_bus.dp0))
		else $error("pointer moved without a completed move");

	chk_step_down_one: assert property (
		move_done && !sfr_wr && ptr_bus.ctrl[STEP_EN_BIT] && ptr_bus.ctrl[SEL_BIT] &&
		ptr_bus.ctrl[DIR1_BIT] |=> ptr_bus.dp1 == 16'($past(ptr_bus.dp1) - 16'h0001))
		else $error("second pointer did not step down");

	chk_data_addr_sel: assert property (
		data_address == (ptr_bus.ctrl[SEL_BIT] ? ptr_bus.dp1 : ptr_bus.dp0))
		else $error("data address not the selected pointer");

	chk_div_zero_keep: assert property (
		alu_go && alu_op == OP_DIV && aux_out == 8'h00 && !wr_acc && !wr_aux |=>
		$stable(accumulator) && $stable(aux_out))
		else $error("divide by zero changed a result byte");

	chk_rdata_idle: assert property (
		!sfr_rd |=> sfr_rdata == 8'h00 && !sfr_hit)
		else $error("read data not cleared without a read");

	chk_sph_write_bit: assert property (
		wr_sph |=> stack_address[8] == $past(sfr_wdata[0]))
		else $error("stack high bit not written");

	cov_push_pop: cover property (stack_op == STK_PUSH ##1 stack_op == STK_POP);
	cov_mul_done: cover property (alu_go && alu_op == OP_MUL);
	cov_div_zero: cover property (alu_go && alu_op == OP_DIV && aux_out == 8'h00);
	cov_move_toggle: cover property (move_done && ptr_bus.ctrl[TOGGLE_BIT] &&
		ptr_bus.ctrl[STEP_EN_BIT]);
	cov_irq_entry: cover property (stack_op == STK_IRQ && ptr_bus.ctrl[SPACING_BIT]);
endmodule // cpu_core_pointer_registers

/* File: src/data_pointer_unit.sv */
// Two data pointers with their control register, auto-step and auto-toggle
`timescale 1ns/1ns
module data_pointer_unit (
	input logic clk_sys,
	input logic rstn,
	ptr_link.unit lnk
);
	import core_regs_pkg::*;

	logic sel, step_now, flip_now;
	logic [15:0] stepped0, stepped1, next_dp0, next_dp1;
	logic [7:0] next_ctrl;

	// One step up or down, wrapping at the ends of the space
	function automatic logic [15:0] step16(input logic [15:0] v, input logic down);
		step16 = down ? v - 16'h0001 : v + 16'h0001;
	endfunction

	// Step and toggle fire once per completed pointer-addressed move
	assign sel = lnk.ctrl[SEL_BIT];
	assign step_now = lnk.move_done && lnk.ctrl[STEP_EN_BIT];
	assign flip_now = lnk.move_done && lnk.ctrl[TOGGLE_BIT];
	assign stepped0 = (step_now && !sel) ? step16(lnk.dp0, lnk.ctrl[DIR0_BIT]) : lnk.dp0;
	assign stepped1 = (step_now && sel) ? step16(lnk.dp1, lnk.ctrl[DIR1_BIT]) : lnk.dp1;

	// A register write in the same cycle overrides the step on that byte
	assign next_dp0[7:0] = (lnk.wr && lnk.addr == PTR0_LOW_ADDR) ? lnk.wdata : stepped0[7:0];
	assign next_dp0[15:8] = (lnk.wr && lnk.addr == PTR0_HIGH_ADDR) ? lnk.wdata : stepped0[15:8];
	assign next_dp1[7:0] = (lnk.wr && lnk.addr == PTR1_LOW_ADDR) ? lnk.wdata : stepped1[7:0];
	assign next_dp1[15:8] = (lnk.wr && lnk.addr == PTR1_HIGH_ADDR) ? lnk.wdata : stepped1[15:8];
	assign next_ctrl = (lnk.wr && lnk.addr == PTR_CTRL_ADDR) ? (lnk.wdata & PTR_CTRL_WMASK) :
		{lnk.ctrl[7:1], lnk.ctrl[SEL_BIT] ^ flip_now};

	// Pointer bytes, control and the selected address
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lnk.dp0 <= PTR_RST;
			lnk.dp1 <= PTR_RST;
			lnk.ctrl <= PTR_CTRL_RST;
			lnk.data_address <= PTR_RST;
		end else begin
			lnk.dp0 <= next_dp0;
			lnk.dp1 <= next_dp1;
			lnk.ctrl <= next_ctrl;
			lnk.data_address <= next_ctrl[SEL_BIT] ? next_dp1 : next_dp0;
		end
	end
endmodule // data_pointer_unit

/* File: tb/cpu_core_pointer_registers_tb.sv */
// Self-checking bench for the core register set
`timescale 1ns/1ns
module cpu_core_pointer_registers_tb;
	import core_regs_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus signals, outputs and counters
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic alu_go = 1'b0;
	alu_op_t alu_op = OP_ADD;
	logic [7:0] alu_operand = 8'h00;
	stack_op_t stack_op = STK_NONE;
	logic move_done = 1'b0;
	logic [3:0] irq_num = 4'h2;
	logic [7:0] sfr_rdata, accumulator, aux_out;
	logic sfr_hit, bit_test;
	logic [3:0] psw_flags;
	logic [8:0] stack_address;
	logic [15:0] data_address, vector_address;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] ad [7] = '{STACK_LOW_ADDR, PTR0_LOW_ADDR, PTR0_HIGH_ADDR, PTR1_LOW_ADDR,
		PTR1_HIGH_ADDR, ACC_ADDR, AUX_ADDR};

	cpu_core_pointer_registers u_dut (.clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .alu_go(alu_go), .alu_op(alu_op), .alu_operand(alu_operand),
		.stack_op(stack_op), .move_done(move_done), .irq_num(irq_num),
		.accumulator(accumulator), .aux_out(aux_out), .psw_flags(psw_flags),
		.bit_test(bit_test), .stack_address(stack_address), .data_address(data_address),
		.vector_address(vector_address));

	// 20 MHz clock and a hang guard well above the expected run
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Shared driving and checking tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Every strobe set once per step, so back-to-back requests never glitch
	task automatic drive(input logic w, input logic r, input logic g, input logic m,
		input stack_op_t s);
		sfr_wr = w;
		sfr_rd = r;
		alu_go = g;
		move_done = m;
		stack_op = s;
	endtask
	task automatic idle();
		drive(1'b0, 1'b0, 1'b0, 1'b0, STK_NONE);
		@(negedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		drive(1'b1, 1'b0, 1'b0, 1'b0, STK_NONE);
		@(negedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
		sfr_addr = a;
		drive(1'b0, 1'b1, 1'b0, 1'b0, STK_NONE);
		@(negedge clk_sys);
		chk("sfr_rdata", {8'h00, sfr_rdata}, {8'h00, e});
		chk("sfr_hit", {15'h0000, sfr_hit}, {15'h0000, h});
	endtask
	task automatic alu(input alu_op_t op, input logic [7:0] b);
		alu_op = op;
		alu_operand = b;
		drive(1'b0, 1'b0, 1'b1, 1'b0, STK_NONE);
		@(negedge clk_sys);
	endtask
	task automatic stk(input stack_op_t op, input logic [8:0] e);
		drive(1'b0, 1'b0, 1'b0, 1'b0, op);
		@(negedge clk_sys);
		chk("stack_address", {7'h00, stack_address}, {7'h00, e});
	endtask
	task automatic mv();
		drive(1'b0, 1'b0, 1'b0, 1'b1, STK_NONE);
		@(negedge clk_sys);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		idle();
		chk("stack_address", {7'h00, stack_address}, 16'h0007);
		chk("vector_address", vector_address, 16'h8013);
		for (int i = 0; i < 7; i++) begin
			rd(ad[i], (i == 0) ? 8'h07 : 8'h00, 1'b1);
		end
		rd(PTR_CTRL_ADDR, 8'h80, 1'b1);
		rd(STACK_HIGH_ADDR, 8'h00, 1'b1);
		rd(8'h80, 8'h00, 1'b0);
		$display("test reset done");
	endtask
	// Distinct pattern per address shows any aliasing between registers
	task automatic test_regs();
		for (int i = 0; i < 7; i++) begin
			wr(ad[i], ad[i] ^ 8'h5a);
		end
		for (int i = 0; i < 7; i++) begin
			rd(ad[i], ad[i] ^ 8'h5a, 1'b1);
		end
		wr(STACK_HIGH_ADDR, 8'hff);
		wr(8'h87, 8'h55);
		rd(STACK_HIGH_ADDR, 8'h01, 1'b1);
		rd(8'h87, 8'h00, 1'b0);
		$display("test registers done");
	endtask
	task automatic test_stack();
		wr(STACK_HIGH_ADDR, 8'h00);
		wr(STACK_LOW_ADDR, 8'h0a);
		chk("stack_address", {7'h00, stack_address}, 16'h000a);
		rd(STACK_LOW_ADDR, 8'h0a, 1'b1);
		stk(STK_PUSH, 9'h00b);
		stk(STK_LCALL, 9'h00d);
		stk(STK_ACALL, 9'h00f);
		stk(STK_IRQ, 9'h011);
		stk(STK_POP, 9'h010);
		stk(STK_RET, 9'h00e);
		stk(STK_RETI, 9'h00c);
		wr(STACK_LOW_ADDR, 8'hff);
		stk(STK_PUSH, 9'h100);
		rd(STACK_HIGH_ADDR, 8'h01, 1'b1);
		stk(STK_POP, 9'h0ff);
		wr(STACK_HIGH_ADDR, 8'h01);
		stk(STK_PUSH, 9'h000);
		$display("test stack done");
	endtask
	task automatic test_alu();
		alu_op_t ops [12] = '{OP_ADD, OP_SUBB, OP_INC, OP_DEC, OP_AND, OP_OR, OP_XOR,
			OP_CPL, OP_RL, OP_CMP, OP_RR, OP_SETB};
		logic [7:0] av [12] = '{8'h03, 8'h08, 8'hff, 8'h00, 8'hf0, 8'hf0, 8'hff, 8'h5a,
			8'h81, 8'h55, 8'h81, 8'h00};
		logic [7:0] bv [12] = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h3c, 8'h0f, 8'h0f, 8'h00,
			8'h00, 8'h11, 8'h00, 8'h07};
		logic [7:0] ev [12] = '{8'h08, 8'h05, 8'h00, 8'hff, 8'h30, 8'hff, 8'hf0, 8'ha5,
			8'h03, 8'h55, 8'hc0, 8'h80};
		for (int i = 0; i < 12; i++) begin
			wr(ACC_ADDR, av[i]);
			alu(ops[i], bv[i]);
			chk("accumulator", {8'h00, accumulator}, {8'h00, ev[i]});
		end
		wr(ACC_ADDR, 8'hff);
		alu(OP_ADD, 8'h01);
		chk("psw_flags", {12'h000, psw_flags}, 16'h000c);
		wr(ACC_ADDR, 8'h12);
		wr(AUX_ADDR, 8'h10);
		alu(OP_MUL, 8'h10);
		chk("mul low", {8'h00, accumulator}, 16'h0020);
		chk("mul high", {8'h00, aux_out}, 16'h0001);
		wr(AUX_ADDR, 8'h03);
		alu(OP_DIV, 8'h03);
		chk("div quotient", {8'h00, accumulator}, 16'h000a);
		chk("div remainder", {8'h00, aux_out}, 16'h0002);
		wr(AUX_ADDR, 8'h00);
		alu(OP_DIV, 8'h00);
		chk("div zero aux", {8'h00, aux_out}, 16'h0000);
		chk("div zero acc", {8'h00, accumulator}, 16'h000a);
		chk("div zero ov", {15'h0000, psw_flags[1]}, 16'h0001);
		wr(ACC_ADDR, 8'h04);
		alu(OP_TESTB, 8'h02);
		chk("bit_test", {15'h0000, bit_test}, 16'h0001);
		chk("testb acc", {8'h00, accumulator}, 16'h0004);
		$display("test alu done");
	endtask
	task automatic test_pointers();
		wr(PTR1_HIGH_ADDR, 8'h12);
		wr(PTR1_LOW_ADDR, 8'h34);
		wr(PTR0_LOW_ADDR, 8'h10);
		wr(PTR0_HIGH_ADDR, 8'h00);
		wr(PTR_CTRL_ADDR, 8'h0c);
		chk("data_address", data_address, 16'h0010);
		mv();
		chk("data_address", data_address, 16'h1234);
		rd(PTR0_LOW_ADDR, 8'h11, 1'b1);
		rd(PTR_CTRL_ADDR, 8'h0d, 1'b1);
		wr(PTR1_LOW_ADDR, 8'h00);
		wr(PTR_CTRL_ADDR, 8'h19);
		mv();
		chk("data_address", data_address, 16'h11ff);
		wr(PTR_CTRL_ADDR, 8'h28);
		mv();
		chk("data_address", data_address, 16'h0010);
		wr(PTR_CTRL_ADDR, 8'h20);
		mv();
		chk("data_address", data_address, 16'h0010);
		wr(PTR_CTRL_ADDR, 8'h02);
		rd(PTR_CTRL_ADDR, 8'h00, 1'b1);
		$display("test pointers done");
	endtask
	// Vector number 15 is the top of the field, the worst case for the offset
	task automatic test_vectors();
		logic [7:0] c;
		logic [15:0] n;
		logic [15:0] e;
		for (int i = 0; i < 4; i++) begin
			c = 8'(i) << 6;
			n = 16'(i * 5);
			irq_num = n[3:0];
			wr(PTR_CTRL_ADDR, c);
			idle();
			e = (c[7] ? 16'h8000 : 16'h0300) + (c[6] ? (n + 16'h0001) * 16'h0003 :
				n * 16'h0008 + 16'h0003);
			chk("vector_address", vector_address, e);
		end
		$display("test vectors done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Reset for 16 cycles, then the scenarios in order
	initial begin
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		test_reset();
		test_regs();
		test_stack();
		test_alu();
		test_pointers();
		test_vectors();
		complete_run();
	end
endmodule // cpu_core_pointer_registers_tb
